// ===== verilog/fsp_pkg.sv
// constants and types for the flash status and protection register logic
package fsp_pkg;
  // opcodes
  localparam logic [7:0] OP_READ_PRIMARY = 8'h05;
  localparam logic [7:0] OP_READ_SECONDARY_A = 8'h09;
  localparam logic [7:0] OP_READ_SECONDARY_B = 8'h35;
  localparam logic [7:0] OP_FOUR_LINE_ENTRY = 8'h38;
  localparam logic [7:0] OP_FOUR_LINE_EXIT = 8'hff;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_SECONDARY_WRITE = 8'h31;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h32;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_SECURITY_PROGRAM = 8'h42;
  localparam logic [7:0] OP_SECURITY_ERASE = 8'h44;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;

  // non-volatile defaults
  localparam logic RST_SRP = 1'b0;
  localparam logic RST_TB = 1'b0;
  localparam logic [3:0] RST_BP = 4'h0;
  localparam logic RST_CMP = 1'b0;
  localparam logic [2:0] RST_LOCK = 3'h0;
  localparam logic RST_QE = 1'b1;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STATUS_WRITE_NS = 10000;
  localparam int STATUS_WRITE_CYC = STATUS_WRITE_NS / CLK_PERIOD_NS;
  localparam int SW_CNT_W = 11;

  // pin sampling: {write protect, chip select, serial clock, dq[3:0]}
  localparam int PIN_W = 7;
  localparam int PIN_WP = 6;
  localparam int PIN_CS = 5;
  localparam int PIN_CLK = 4;
  localparam logic [PIN_W-1:0] PIN_IDLE = 7'h7f;
  localparam int DQ_OUT_BIT = 1;
  localparam logic [3:0] OE_NONE = 4'hf;
  localparam logic [3:0] OE_SINGLE = 4'hd;
  localparam logic [3:0] OE_QUAD = 4'h0;

  // framing
  localparam logic [2:0] STEPS_SINGLE = 3'h7;
  localparam logic [2:0] STEPS_QUAD = 3'h1;
  localparam logic [2:0] BYTES_NONE = 3'h0;
  localparam logic [2:0] BYTES_ONE = 3'h1;
  localparam logic [2:0] BYTES_TWO = 3'h2;
  localparam logic [2:0] BYTES_ADDR = 3'h3;
  localparam logic [2:0] BYTES_MAX = 3'h4;

  // protection geometry: 256 blocks of 64 KiB, 24-bit address
  localparam int BLK_MSB = 23;
  localparam int BLK_LSB = 16;
  localparam logic [8:0] BLOCKS = 9'h100;
  localparam logic [3:0] BP_LEVEL_ALL = 4'h9;
  localparam logic [8:0] ONE_BLOCK = 9'h001;
  localparam int SEC_MSB = 13;
  localparam int SEC_LSB = 12;
  localparam logic [1:0] SEC_NONE = 2'h3;

  typedef struct packed {
    logic status_protect_lock; logic tb; logic [3:0] bp; logic write_enable_latch; logic write_in_progress;
  } fsp_primary_t;

  typedef struct packed {
    logic erase_suspended_flag; logic cmp; logic lock0; logic lock1; logic lock2;
    logic program_suspended_flag; logic qe; logic rsvd;
  } fsp_secondary_t;

  typedef enum logic [3:0] {
    REQ_NONE = 4'h0, REQ_PROGRAM = 4'h1, REQ_QUAD_PROGRAM = 4'h2,
    REQ_SECTOR_ERASE = 4'h3, REQ_HALF_BLOCK_ERASE = 4'h4, REQ_BLOCK_ERASE = 4'h5,
    REQ_CHIP_ERASE = 4'h6, REQ_SECURITY_PROGRAM = 4'h7, REQ_SECURITY_ERASE = 4'h8,
    REQ_SUSPEND = 4'h9, REQ_RESUME = 4'ha
  } fsp_req_kind_t;

  typedef struct packed {
    fsp_req_kind_t kind;
    logic [23:0] addr;
  } fsp_req_t;

  typedef enum logic [1:0] {
    PH_OPCODE = 2'b00, PH_DATA = 2'b01, PH_READ = 2'b10
  } fsp_phase_t;
endpackage

// ===== verilog/fsp_status_regs.sv
// serial status and protection register logic of the flash device
//
// Function
// - primary status read answered at any time
// - status byte repeats while chip select low
// - two secondary read opcodes, same repeat behaviour
// - four-line mode carries opcode and data nibble-wide
// - primary byte: lock, top/bottom, level, latch, busy
// - busy flag high during write, program, erase
// - latch clear rejects writes, programs and erases
// - protected region ignores program and erase
// - protect level writable only outside hardware protection
// - chip erase only with nothing protected
// - top/bottom zero protects top, one bottom
// - lock plus low pin refuses status write while quad enable is off
// - secondary byte: suspends, complement, locks, quad, reserved
// - erase suspended flag set on suspend, cleared resume
// - program suspended flag set on suspend, cleared resume
// - complement bit defaults zero, inverts region
// - security lock bits set once, block sector
// - quad enable defaults one
// - reserved secondary bit reads zero
// - volatile bits zero after reset
// - latch set command sets write latch
// - latch clear command clears write latch
// - latch cleared when write operations complete
`timescale 1ns/100ps
module fsp_status_regs import fsp_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] dq_i,
  input wire logic wp_n_i,
  input wire logic engine_busy_i,
  input wire logic engine_done_i,
  output logic [3:0] dq_o,
  output logic [3:0] dq_oe_n_o,
  output fsp_req_t req_o,
  output logic quad_mode_o,
  output logic quad_enable_o
);

  logic [PIN_W-1:0] pin_meta, pin_sync;
  logic sclk_q, cs_q, cs_s, wp_n_s, sclk_rise, sclk_fall, cs_rise;
  logic [3:0] dq_s;

  fsp_phase_t phase;
  logic [2:0] bit_step, byte_cnt;
  logic [7:0] shift_in, opcode, next_shift;
  logic [7:0] byte_buf [0:3];
  logic byte_last;

  logic [7:0] out_sreg, out_src;
  logic [2:0] out_step;

  logic status_protect_lock, tb, cmp, write_enable_latch, erase_suspended_flag, program_suspended_flag, act_erase, sw_busy, sw_done, write_in_progress;
  logic hardware_protected_mode, write_ok, region_ok, exec, sec_locked, do_status_write_cmd, do_secondary_status_write_cmd;
  logic [3:0] bp;
  logic [2:0] lock;
  logic [SW_CNT_W-1:0] sw_cnt;
  logic [23:0] addr;
  logic [1:0] sec_idx;
  fsp_primary_t primary, wr_primary;
  fsp_secondary_t secondary, wr_secondary;
  fsp_req_kind_t next_kind;

  function automatic logic is_status_read(input logic [7:0] op);
    is_status_read = (op == OP_READ_PRIMARY) || (op == OP_READ_SECONDARY_A) ||
                     (op == OP_READ_SECONDARY_B);
  endfunction

  // number of 64 KiB blocks covered by a protect level
  function automatic logic [8:0] prot_count(input logic [3:0] level);
    if (level == 4'h0) begin
      prot_count = 9'h000;
    end else if (level >= BP_LEVEL_ALL) begin
      prot_count = BLOCKS;
    end else begin
      prot_count = ONE_BLOCK << (level - 4'h1);
    end
  endfunction

  // region grows from the top or bottom, then the complement inverts it
  function automatic logic is_protected(input logic [23:0] a, input logic [3:0] level,
                                        input logic bottom, input logic inv);
    logic [8:0] cnt;
    logic [8:0] blk;
    logic hit;
    cnt = prot_count(level);
    blk = {1'b0, a[BLK_MSB:BLK_LSB]};
    hit = bottom ? (blk < cnt) : (blk >= (BLOCKS - cnt));
    is_protected = hit ^ inv;
  endfunction

  // two-flop synchronisers; link clock is sampled, not used as a clock
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
      sclk_q <= 1'b1;
      cs_q <= 1'b1;
    end else begin
      pin_meta <= {wp_n_i, cs_n_i, sclk_i, dq_i};
      pin_sync <= pin_meta;
      sclk_q <= pin_sync[PIN_CLK];
      cs_q <= pin_sync[PIN_CS];
    end
  end

  assign cs_s = pin_sync[PIN_CS];
  assign wp_n_s = pin_sync[PIN_WP];
  assign dq_s = pin_sync[3:0];
  assign sclk_rise = pin_sync[PIN_CLK] & ~sclk_q & ~cs_s;
  assign sclk_fall = ~pin_sync[PIN_CLK] & sclk_q & ~cs_s;
  assign cs_rise = cs_s & ~cs_q;

  // shift in most significant first, one line or four
  assign next_shift = quad_mode_o ? {shift_in[3:0], dq_s} : {shift_in[6:0], dq_s[0]};
  assign byte_last = bit_step == (quad_mode_o ? STEPS_QUAD : STEPS_SINGLE);

  // frame collection: opcode then up to four bytes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase <= PH_OPCODE;
      bit_step <= 3'h0;
      byte_cnt <= BYTES_NONE;
      shift_in <= 8'h00;
      opcode <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        byte_buf[i] <= 8'h00;
      end
    end else if (cs_s) begin
      phase <= PH_OPCODE;
      bit_step <= 3'h0;
      byte_cnt <= BYTES_NONE;
    end else if (sclk_rise && phase != PH_READ) begin
      shift_in <= next_shift;
      if (byte_last) begin
        bit_step <= 3'h0;
        if (phase == PH_OPCODE) begin
          opcode <= next_shift;
          phase <= is_status_read(next_shift) ? PH_READ : PH_DATA;
        end else if (byte_cnt != BYTES_MAX) begin
          byte_buf[byte_cnt[1:0]] <= next_shift;
          byte_cnt <= byte_cnt + 3'h1;
        end
      end else begin
        bit_step <= bit_step + 3'h1;
      end
    end
  end

  // live status bytes; busy combines the status write cycle and the engines
  assign write_in_progress = sw_busy | engine_busy_i;
  assign primary = '{status_protect_lock: status_protect_lock, tb: tb, bp: bp, write_enable_latch: write_enable_latch, write_in_progress: write_in_progress};
  assign secondary = '{erase_suspended_flag: erase_suspended_flag, cmp: cmp, lock0: lock[0], lock1: lock[1], lock2: lock[2],
                       program_suspended_flag: program_suspended_flag, qe: quad_enable_o, rsvd: 1'b0};

  // a fresh snapshot is taken at each byte boundary so polling sees updates
  assign out_src = (out_step != 3'h0) ? out_sreg :
                   (opcode == OP_READ_PRIMARY) ? primary : secondary;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dq_o <= 4'h0;
      dq_oe_n_o <= OE_NONE;
      out_sreg <= 8'h00;
      out_step <= 3'h0;
    end else if (cs_s) begin
      dq_o <= 4'h0;
      dq_oe_n_o <= OE_NONE;
      out_step <= 3'h0;
    end else if (sclk_fall && phase == PH_READ) begin
      if (quad_mode_o) begin
        dq_o <= out_src[7:4];
        out_sreg <= {out_src[3:0], 4'h0};
        dq_oe_n_o <= OE_QUAD;
        out_step <= (out_step == STEPS_QUAD) ? 3'h0 : out_step + 3'h1;
      end else begin
        dq_o <= 4'h0;
        dq_o[DQ_OUT_BIT] <= out_src[7];
        out_sreg <= {out_src[6:0], 1'b0};
        dq_oe_n_o <= OE_SINGLE;
        out_step <= (out_step == STEPS_SINGLE) ? 3'h0 : out_step + 3'h1;
      end
    end
  end

  // commands act when chip select rises on a whole byte
  assign exec = cs_rise && phase == PH_DATA && bit_step == 3'h0;
  assign hardware_protected_mode = status_protect_lock & ~wp_n_s & ~quad_enable_o;
  // new writes are refused while the running cycle is busy
  assign write_ok = write_enable_latch & ~write_in_progress;
  assign region_ok = write_ok && !is_protected(addr, bp, tb, cmp);
  assign addr = {byte_buf[0], byte_buf[1], byte_buf[2]};
  assign sec_idx = addr[SEC_MSB:SEC_LSB];
  assign sec_locked = (sec_idx == SEC_NONE) || lock[sec_idx];
  assign wr_primary = fsp_primary_t'(byte_buf[0]);
  assign wr_secondary = fsp_secondary_t'((byte_cnt == BYTES_TWO) ? byte_buf[1] : byte_buf[0]);

  assign do_status_write_cmd = exec && opcode == OP_STATUS_WRITE && write_ok && !hardware_protected_mode &&
                   (byte_cnt == BYTES_ONE || byte_cnt == BYTES_TWO);
  assign do_secondary_status_write_cmd = exec && opcode == OP_SECONDARY_WRITE && write_ok &&
                    byte_cnt == BYTES_ONE;

  // non-volatile bits, restored to their defaults by reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_protect_lock <= RST_SRP;
      tb <= RST_TB;
      bp <= RST_BP;
      cmp <= RST_CMP;
      lock <= RST_LOCK;
      quad_enable_o <= RST_QE;
    end else if (do_status_write_cmd) begin
      status_protect_lock <= wr_primary.status_protect_lock;
      tb <= wr_primary.tb;
      bp <= wr_primary.bp;
      if (byte_cnt == BYTES_TWO) begin
        cmp <= wr_secondary.cmp;
        lock <= lock | {wr_secondary.lock2, wr_secondary.lock1, wr_secondary.lock0};
        quad_enable_o <= wr_secondary.qe;
      end
    end else if (do_secondary_status_write_cmd) begin
      if (!hardware_protected_mode) begin
        cmp <= wr_secondary.cmp;
      end
      // one-time bits: ones stick, zeros written later are ignored
      lock <= lock | {wr_secondary.lock2, wr_secondary.lock1, wr_secondary.lock0};
      quad_enable_o <= wr_secondary.qe;
    end
  end

  // self-timed status write cycle
  assign sw_busy = sw_cnt != '0;
  assign sw_done = sw_cnt == SW_CNT_W'(1);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sw_cnt <= '0;
    end else if (do_status_write_cmd || do_secondary_status_write_cmd) begin
      sw_cnt <= SW_CNT_W'(STATUS_WRITE_CYC);
    end else if (sw_busy) begin
      sw_cnt <= sw_cnt - SW_CNT_W'(1);
    end
  end

  // write latch; a set is refused while busy, so it wins only over an engine completion that comes with engine busy low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      write_enable_latch <= 1'b0;
    end else if (exec && opcode == OP_LATCH_SET && byte_cnt == BYTES_NONE && !write_in_progress) begin
      write_enable_latch <= 1'b1;
    end else if (exec && opcode == OP_LATCH_CLEAR && byte_cnt == BYTES_NONE) begin
      write_enable_latch <= 1'b0;
    end else if (sw_done || engine_done_i) begin
      write_enable_latch <= 1'b0;
    end
  end

  // array requests; program and erase checked against latch and protection, suspend and resume against neither
  always_comb begin
    next_kind = REQ_NONE;
    unique case (opcode)
      OP_PAGE_PROGRAM, OP_QUAD_PAGE_PROGRAM: begin
        if (region_ok && byte_cnt == BYTES_MAX &&
            !(quad_mode_o && opcode == OP_QUAD_PAGE_PROGRAM)) begin
          next_kind = (opcode == OP_PAGE_PROGRAM) ? REQ_PROGRAM : REQ_QUAD_PROGRAM;
        end
      end
      OP_SECTOR_ERASE, OP_HALF_BLOCK_ERASE, OP_BLOCK_ERASE: begin
        if (region_ok && byte_cnt == BYTES_ADDR) begin
          next_kind = (opcode == OP_SECTOR_ERASE) ? REQ_SECTOR_ERASE :
                      (opcode == OP_BLOCK_ERASE) ? REQ_BLOCK_ERASE : REQ_HALF_BLOCK_ERASE;
        end
      end
      OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
        if (write_ok && byte_cnt == BYTES_NONE &&
            prot_count(bp) == (cmp ? BLOCKS : 9'h000)) begin
          next_kind = REQ_CHIP_ERASE;
        end
      end
      OP_SECURITY_PROGRAM, OP_SECURITY_ERASE: begin
        if (write_ok && !sec_locked &&
            byte_cnt == ((opcode == OP_SECURITY_ERASE) ? BYTES_ADDR : BYTES_MAX)) begin
          next_kind = (opcode == OP_SECURITY_ERASE) ? REQ_SECURITY_ERASE :
                      REQ_SECURITY_PROGRAM;
        end
      end
      OP_SUSPEND: begin
        if (byte_cnt == BYTES_NONE && engine_busy_i && !sw_busy) begin
          next_kind = REQ_SUSPEND;
        end
      end
      OP_RESUME: begin
        if (byte_cnt == BYTES_NONE && (erase_suspended_flag || program_suspended_flag)) begin
          next_kind = REQ_RESUME;
        end
      end
      default: next_kind = REQ_NONE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_o <= '{kind: REQ_NONE, addr: 24'h000000};
    end else if (exec) begin
      req_o <= '{kind: next_kind, addr: addr};
    end else begin
      req_o.kind <= REQ_NONE;
    end
  end

  // remembers whether the running array job erases or programs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_erase <= 1'b0;
    end else if (exec && next_kind inside {REQ_PROGRAM, REQ_QUAD_PROGRAM,
                                           REQ_SECURITY_PROGRAM}) begin
      act_erase <= 1'b0;
    end else if (exec && next_kind inside {REQ_SECTOR_ERASE, REQ_HALF_BLOCK_ERASE,
                                           REQ_BLOCK_ERASE, REQ_CHIP_ERASE,
                                           REQ_SECURITY_ERASE}) begin
      act_erase <= 1'b1;
    end
  end

  // suspend indicators
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      erase_suspended_flag <= 1'b0;
      program_suspended_flag <= 1'b0;
    end else if (exec && next_kind == REQ_SUSPEND) begin
      erase_suspended_flag <= act_erase;
      program_suspended_flag <= ~act_erase;
    end else if (exec && next_kind == REQ_RESUME) begin
      erase_suspended_flag <= 1'b0;
      program_suspended_flag <= 1'b0;
    end
  end

  // four-line mode needs the quad enable bit set
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      quad_mode_o <= 1'b0;
    end else if (exec && byte_cnt == BYTES_NONE) begin
      if (opcode == OP_FOUR_LINE_ENTRY && !quad_mode_o && quad_enable_o) begin
        quad_mode_o <= 1'b1;
      end else if (opcode == OP_FOUR_LINE_EXIT && quad_mode_o) begin
        quad_mode_o <= 1'b0;
      end
    end
  end

endmodule

// ===== verification/fsp_status_regs_sva.sv
// port-level assertions for the status and protection register block
`timescale 1ns/100ps
module fsp_status_regs_sva import fsp_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] dq_i,
  input wire logic wp_n_i,
  input wire logic engine_busy_i,
  input wire logic engine_done_i,
  input wire logic [3:0] dq_o,
  input wire logic [3:0] dq_oe_n_o,
  input wire fsp_req_t req_o,
  input wire logic quad_mode_o,
  input wire logic quad_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_oe_idle_cs: assert property (cs_n_i [*6] |-> dq_oe_n_o == OE_NONE)
    else $error("data pins driven with chip select high");
  a_req_one_cycle: assert property (req_o.kind != REQ_NONE |=> req_o.kind == REQ_NONE)
    else $error("engine request longer than one cycle");
  // commands only act once the frame is closed
  a_req_after_cs: assert property (req_o.kind != REQ_NONE |-> cs_n_i && $past(cs_n_i, 2))
    else $error("engine request inside a frame");
  a_quad_oe_mode: assert property (dq_oe_n_o == OE_QUAD |-> quad_mode_o)
    else $error("four-line output outside four-line mode");
  a_single_oe_mode: assert property (dq_oe_n_o == OE_SINGLE |-> !quad_mode_o)
    else $error("single-line output in four-line mode");
  a_unused_dq_zero: assert property (dq_oe_n_o != OE_QUAD |-> dq_o[3:2] == 2'h0 && !dq_o[0])
    else $error("unused data output not low");
  a_mode_at_cs: assert property ($changed(quad_mode_o) |-> cs_n_i)
    else $error("mode changed inside a frame");
  a_qe_at_cs: assert property ($changed(quad_enable_o) |-> cs_n_i)
    else $error("quad enable changed inside a frame");
  a_quad_needs_qe: assert property ($rose(quad_mode_o) |-> quad_enable_o)
    else $error("four-line mode entered with quad enable low");
  a_reset_state: assert property ($fell(rst_i) |-> quad_enable_o && !quad_mode_o
    && dq_oe_n_o == OE_NONE)
    else $error("wrong state after reset");
endmodule
bind fsp_status_regs fsp_status_regs_sva chk (.clk_i, .rst_i, .cs_n_i, .sclk_i, .dq_i, .wp_n_i,
  .engine_busy_i, .engine_done_i, .dq_o, .dq_oe_n_o, .req_o, .quad_mode_o, .quad_enable_o);

// ===== verification/fsp_host_model.sv
// host spi controller model driving chip select, serial clock and data pins
`timescale 1ns/100ps
module fsp_host_model import fsp_pkg::*; (
  input wire logic clk_i,
  input wire logic [3:0] dev_dq_i,
  input wire logic [3:0] dev_oe_n_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] dq_o
);
  logic [3:0] drv_en = 4'h0;
  logic [3:0] drv_val = 4'h0;
  logic tog = 1'b0;
  // released lines wander so a stale level never passes for data
  always @(posedge clk_i) tog <= ~tog;
  assign dq_o = (drv_en & drv_val) | (~drv_en & ~dev_oe_n_i & dev_dq_i)
    | (~drv_en & dev_oe_n_i & {4{tog}});
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
  end
  // mode 0: data set while the clock is low, sampled on the rise
  task automatic step(input logic quad, input logic [3:0] val, input logic drive,
      output logic [3:0] got);
    drv_en = drive ? (quad ? 4'hf : 4'h1) : 4'h0;
    drv_val = val;
    #80 sclk_o = 1'b1;
    got = dq_o;
    #80 sclk_o = 1'b0;
  endtask
  task automatic frame(input logic quad, input logic [39:0] tx, input int ntx, input int nrx,
      output logic [15:0] rx);
    logic [3:0] got;
    logic [39:0] sh;
    int w;
    w = quad ? 4 : 1;
    sh = tx;
    rx = 16'h0;
    @(posedge clk_i);
    #1 cs_n_o = 1'b0;
    for (int i = 0; i < ntx * 8; i += w) begin
      step(quad, quad ? sh[39:36] : {3'h0, sh[39]}, 1'b1, got);
      sh = sh << w;
    end
    for (int i = 0; i < nrx * 8; i += w) begin
      step(quad, 4'h0, 1'b0, got);
      rx = quad ? {rx[11:0], got} : {rx[14:0], got[DQ_OUT_BIT]};
    end
    #80 cs_n_o = 1'b1;
    drv_en = 4'h0;
    #240;
  endtask
endmodule

// ===== verification/fsp_status_regs_bench.sv
// self-checking bench for the flash status and protection registers
`timescale 1ns/100ps
module fsp_status_regs_bench import fsp_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wp_n_i = 1'b1;
  logic busy = 1'b0;
  logic done = 1'b0;
  logic qm = 1'b0;
  wire cs_n;
  wire sclk;
  wire [3:0] dq_w;
  logic [3:0] dev_dq;
  logic [3:0] dev_oe_n;
  fsp_req_t req_o;
  logic quad_mode;
  logic qe;
  fsp_req_kind_t seen = REQ_NONE;
  logic [23:0] seen_addr;
  logic [15:0] rx;
  logic [7:0] ep;
  logic [7:0] es;
  logic [7:0] v;
  logic [7:0] blk;
  int fails = 0;
  int total_checks = 0;
  logic [7:0] ops [3] = '{OP_PAGE_PROGRAM, OP_SECTOR_ERASE, OP_BLOCK_ERASE};
  fsp_req_kind_t kinds [3] = '{REQ_PROGRAM, REQ_SECTOR_ERASE, REQ_BLOCK_ERASE};
  initial forever #5 clk_i = ~clk_i;
  fsp_host_model host (.clk_i(clk_i), .dev_dq_i(dev_dq), .dev_oe_n_i(dev_oe_n), .cs_n_o(cs_n),
    .sclk_o(sclk), .dq_o(dq_w));
  fsp_status_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .dq_i(dq_w),
    .wp_n_i(wp_n_i), .engine_busy_i(busy), .engine_done_i(done), .dq_o(dev_dq),
    .dq_oe_n_o(dev_oe_n), .req_o(req_o), .quad_mode_o(quad_mode), .quad_enable_o(qe));
  // cleared inside each frame, so it holds only that frame's request
  always @(posedge clk_i) begin
    if (!cs_n) begin
      seen <= REQ_NONE;
    end else if (req_o.kind !== REQ_NONE) begin
      seen <= req_o.kind;
      seen_addr <= req_o.addr;
    end
  end
  task automatic end_of_test();
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmd(input logic [39:0] tx, input int n);
    host.frame(qm, tx, n, 0, rx);
  endtask
  // two bytes in one frame: the byte must repeat
  task automatic rdc(input logic [7:0] op, input logic [7:0] exp, input string what);
    host.frame(qm, {op, 32'h0}, 1, 2, rx);
    chk8(rx[15:8], exp, what);
    chk8(rx[7:0], exp, what);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 20; i++) begin
      host.frame(qm, {OP_READ_PRIMARY, 32'h0}, 1, 1, rx);
      if (rx[0] === 1'b0) return;
    end
    fails++;
    $display("BAD %0t busy never cleared", $time);
    end_of_test();
  endtask
  task automatic wr(input logic [7:0] op, input logic [7:0] val);
    cmd({OP_LATCH_SET, 32'h0}, 1);
    cmd({op, val, 24'h0}, 2);
    if (op == OP_STATUS_WRITE) begin
      host.frame(qm, {OP_READ_PRIMARY, 32'h0}, 1, 1, rx);
      chk8({7'h0, rx[0]}, 8'h01, "write busy");
    end
    wait_idle();
  endtask
  task automatic set_in(input logic b, input logic w);
    @(posedge clk_i);
    #1 busy = b;
    wp_n_i = w;
  endtask
  task automatic prog(input logic [7:0] op, input logic [23:0] a, input int n,
      input fsp_req_kind_t k);
    cmd({OP_LATCH_SET, 32'h0}, 1);
    cmd({op, a, 8'ha5}, n);
    chk8({4'h0, seen}, {4'h0, k}, "request");
    // chip erase carries no address, so only addressed requests are compared
    if (k != REQ_NONE && n > 1) begin
      chk8(seen_addr[23:16], a[23:16], "request block");
      chk8(seen_addr[7:0], a[7:0], "request low byte");
    end
    @(posedge clk_i);
    #1 done = 1'b1;
    @(posedge clk_i);
    #1 done = 1'b0;
    rdc(OP_READ_PRIMARY, ep, "latch after done");
  endtask
  task automatic susp(input logic [7:0] m);
    set_in(1'b1, 1'b1);
    cmd({OP_SUSPEND, 32'h0}, 1);
    rdc(OP_READ_SECONDARY_A, es | m, "suspended");
    cmd({OP_RESUME, 32'h0}, 1);
    rdc(OP_READ_SECONDARY_B, es, "resumed");
    set_in(1'b0, 1'b1);
  endtask
  // levels 1 to 9 guard 2^(n-1) blocks from the chosen end, 0 none, higher levels all 256; complement flips it
  function automatic logic prot(input logic [7:0] p, input logic cmp, input logic [7:0] b);
    int n;
    n = (p[5:2] == 4'h0) ? 0 : (p[5:2] >= BP_LEVEL_ALL) ? 256 : (1 << (p[5:2] - 1));
    return (p[6] ? (int'(b) < n) : (int'(b) >= 256 - n)) ^ cmp;
  endfunction
  task automatic both_ends(input int k);
    for (int e = 0; e < 2; e++) begin
      blk = e ? 8'hff : 8'h00;
      // erases take exactly the three address bytes, programs one data byte more
      prog(ops[k], {blk, 16'($urandom)}, (k == 0) ? 5 : 4,
        prot(ep, es[6], blk) ? REQ_NONE : kinds[k]);
    end
  endtask
  initial begin
    #900000;
    fails++;
    $display("BAD %0t run too long", $time);
    end_of_test();
  end
  initial begin
    void'($urandom(54268));
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (5) @(posedge clk_i);
    ep = 8'h00;
    es = 8'h02;
    chk8({7'h0, qe}, 8'h01, "quad enable pin");
    rdc(OP_READ_PRIMARY, ep, "reset primary");
    rdc(OP_READ_SECONDARY_A, es, "secondary a");
    rdc(OP_READ_SECONDARY_B, es, "secondary b");
    set_in(1'b1, 1'b1);
    rdc(OP_READ_PRIMARY, 8'h01, "busy read");
    set_in(1'b0, 1'b1);
    cmd({OP_STATUS_WRITE, 8'h3c, 24'h0}, 2);
    rdc(OP_READ_PRIMARY, ep, "write without latch");
    cmd({OP_LATCH_SET, 32'h0}, 1);
    rdc(OP_READ_PRIMARY, 8'h02, "latch set");
    cmd({OP_LATCH_CLEAR, 32'h0}, 1);
    rdc(OP_READ_PRIMARY, 8'h00, "latch clear");
    for (int k = 0; k < 3; k++) begin
      v = {2'b00, 4'($urandom_range(8, 1)), 2'b00};
      v[6] = 1'($urandom_range(1, 0));
      wr(OP_STATUS_WRITE, v);
      ep = v;
      rdc(OP_READ_PRIMARY, ep, "protect write");
      both_ends(k);
      prog(OP_CHIP_ERASE_A, 24'h0, 1, REQ_NONE);
    end
    es = 8'h42;
    wr(OP_SECONDARY_WRITE, es);
    both_ends(0);
    es = 8'h02;
    wr(OP_SECONDARY_WRITE, es);
    ep = 8'h00;
    wr(OP_STATUS_WRITE, ep);
    prog(OP_CHIP_ERASE_B, 24'h0, 1, REQ_CHIP_ERASE);
    susp(8'h80);
    prog(OP_PAGE_PROGRAM, 24'h000100, 5, REQ_PROGRAM);
    susp(8'h04);
    cmd({OP_FOUR_LINE_ENTRY, 32'h0}, 1);
    chk8({7'h0, quad_mode}, 8'h01, "quad entry");
    qm = 1'b1;
    rdc(OP_READ_PRIMARY, ep, "quad primary");
    rdc(OP_READ_SECONDARY_B, es, "quad secondary");
    cmd({OP_FOUR_LINE_EXIT, 32'h0}, 1);
    qm = 1'b0;
    chk8({7'h0, quad_mode}, 8'h00, "quad exit");
    // write protect pin only counts once quad enable is off
    es = 8'h00;
    wr(OP_SECONDARY_WRITE, es);
    chk8({7'h0, qe}, 8'h00, "quad enable off");
    ep = 8'h8c;
    wr(OP_STATUS_WRITE, ep);
    set_in(1'b0, 1'b0);
    cmd({OP_LATCH_SET, 32'h0}, 1);
    cmd({OP_STATUS_WRITE, 8'h00, 24'h0}, 2);
    rdc(OP_READ_PRIMARY, 8'h8e, "protected write");
    set_in(1'b0, 1'b1);
    cmd({OP_STATUS_WRITE, 8'h00, 24'h0}, 2);
    wait_idle();
    ep = 8'h00;
    rdc(OP_READ_PRIMARY, ep, "pin released");
    es = 8'h20;
    wr(OP_SECONDARY_WRITE, es);
    prog(OP_SECURITY_PROGRAM, 24'h000000, 5, REQ_NONE);
    prog(OP_SECURITY_PROGRAM, 24'h001000, 5, REQ_SECURITY_PROGRAM);
    wr(OP_SECONDARY_WRITE, 8'h00);
    rdc(OP_READ_SECONDARY_A, es, "lock kept");
    @(posedge clk_i);
    #1 rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (5) @(posedge clk_i);
    rdc(OP_READ_PRIMARY, 8'h00, "second reset");
    chk8({7'h0, qe}, 8'h01, "second reset qe");
    end_of_test();
  end
endmodule
